// *** rtl/ebat_core.sv ***
// Contract
// - Bus error after 1024 unacknowledged cycles
// - Offer edge and level detection modes
// - Acknowledge used only in asynchronous mode
// - Edge mode ends transfer on rise
// - Edge mode only on select five
// - Assert/negate delay allows waiting per edge; not checked here, edge mode tests only wait count EDGE_WAIT_COUNT
// - Level mode ignores acknowledge 2-5 cycles
// - Sample after window; low stalls
// - Low acknowledge after the window pauses transfer
// - Level mode barred on select four
module ebat_core
    import ebat_pkg::*;
#(
    parameter int unsigned TIMEOUT = TIMEOUT_CYCLES     // Time-out in system clocks
)
(
    input  wire logic                   core_clk,       // System clock, 250 MHz
    input  wire logic                   sys_rst,        // Synchronous reset, high
    input  wire logic                   transfer_ack_in,// Acknowledge pin, asynchronous
    input  wire logic                   ack_edge_select,// Global edge mode select
    input  wire ebat_cs_cfg_s [NUM_CS-1:0] cs_cfg,      // Per-select configuration
    input  wire ebat_req_s              req,            // Transfer start
    input  wire logic                   wait_done,      // Programmed wait states elapsed
    output logic                        busy,           // Cycle owned by this block
    output logic                        stall,          // Transfer held off
    output logic                        xfer_end,       // One-cycle end of transfer
    output logic                        bus_error,      // One-cycle time-out error
    output logic                        cfg_error       // Unsupported mode request, sticky
);

    // ------------------------------------------------------------
    // Acknowledge capture
    // ------------------------------------------------------------
    logic ack_level;
    logic ack_rise;

    ebat_sync u_sync (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .async_in   (transfer_ack_in),
        .level_out  (ack_level),
        .rise_pulse (ack_rise)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        ebat_state_e      fsm;
        logic [CNT_W-1:0] tcnt;
        logic [INS_W-1:0] icnt;
        logic             busy;
        logic             stall;
        logic             xfer_end;
        logic             bus_error;
        logic             cfg_error;
    } ebat_core_s;

    localparam logic [CNT_W-1:0] TO_LAST = CNT_W'(TIMEOUT - 1);

    ebat_core_s   st_reg;
    ebat_core_s   st_next;
    ebat_cs_cfg_s sel_cfg;
    logic         edge_ok;
    logic         level_ok;
    logic         timed_out;

    // ------------------------------------------------------------
    // Mode qualification of the requested select
    // ------------------------------------------------------------
    // Decoded combinationally from the live request; the engine holds cfg stable.
    always_comb begin
        sel_cfg  = cs_cfg[req.cs_sel];
        edge_ok  = ack_edge_select && !sel_cfg.sync_mode
                   && (req.cs_sel == EDGE_CS)
                   && (sel_cfg.wait_state_count == EDGE_WAIT_COUNT);
        level_ok = !ack_edge_select && !sel_cfg.sync_mode
                   && sel_cfg.external_wait_enable
                   && (req.cs_sel != SHARED_CS);
    end

    assign timed_out = (st_reg.tcnt == TO_LAST);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        st_next           = st_reg;
        st_next.xfer_end  = 1'b0;
        st_next.bus_error = 1'b0;
        // Time-out counts only while a cycle is open
        if (st_reg.fsm != ST_IDLE) begin
            st_next.tcnt = st_reg.tcnt + CNT_ONE;
        end
        unique case (st_reg.fsm)
            ST_IDLE: begin
                st_next.tcnt  = CNT_ZERO;
                st_next.stall = 1'b0;
                st_next.busy  = 1'b0;
                if (req.start) begin
                    if (edge_ok) begin
                        // Each cycle, even back-to-back, waits for its own rise
                        st_next.fsm   = ST_EDGE;
                        st_next.busy  = 1'b1;
                        st_next.stall = 1'b1;
                    end else if (level_ok) begin
                        st_next.fsm   = ST_INSEN;
                        st_next.icnt  = INS_W'(INSENS_MIN_CYC - 1) + INS_W'(sel_cfg.ack_insensitivity_time);
                        st_next.busy  = 1'b1;
                    end else if (ack_edge_select || sel_cfg.external_wait_enable) begin
                        // Asked for a mode this select cannot use: left to wait states
                        st_next.cfg_error = 1'b1;
                    end
                end
            end
            ST_EDGE: begin
                if (ack_rise) begin
                    st_next.fsm      = ST_IDLE;
                    st_next.xfer_end = 1'b1;
                    st_next.stall    = 1'b0;
                    st_next.busy     = 1'b0;
                end else if (timed_out) begin
                    st_next.fsm       = ST_IDLE;
                    st_next.bus_error = 1'b1;
                    st_next.stall     = 1'b0;
                    st_next.busy      = 1'b0;
                end
            end
            ST_INSEN: begin
                // Acknowledge ignored here; glitches from the device are masked
                if (st_reg.icnt == INS_ZERO) begin
                    st_next.fsm = ST_WAIT;
                end else begin
                    st_next.icnt = st_reg.icnt - INS_W'(1);
                end
            end
            ST_WAIT, ST_PASS: begin
                st_next.stall = !ack_level;
                st_next.fsm   = ack_level ? ST_PASS : ST_WAIT;
                if (ack_level && wait_done) begin
                    st_next.fsm      = ST_IDLE;
                    st_next.xfer_end = 1'b1;
                    st_next.busy     = 1'b0;
                    st_next.stall    = 1'b0;
                end else if (timed_out) begin
                    st_next.fsm       = ST_IDLE;
                    st_next.bus_error = 1'b1;
                    st_next.busy      = 1'b0;
                    st_next.stall     = 1'b0;
                end
            end
            default: begin
                st_next.fsm = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_reg <= '{fsm: ST_IDLE, tcnt: CNT_ZERO, icnt: INS_ZERO, default: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign busy      = st_reg.busy;
    assign stall     = st_reg.stall;
    assign xfer_end  = st_reg.xfer_end;
    assign bus_error = st_reg.bus_error;
    assign cfg_error = st_reg.cfg_error;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_edge_start;
        st_reg.fsm == ST_IDLE && req.start && edge_ok;
    endsequence

    sequence s_level_start;
        st_reg.fsm == ST_IDLE && req.start && level_ok;
    endsequence

    // An error before the last count would cut slow cards short
    chk_timeout_error: assert property (
        bus_error |-> $past(timed_out))
        else $error("bus error before time-out");

    chk_timeout_bound: assert property (
        (busy && st_reg.tcnt == TO_LAST && !xfer_end && st_reg.fsm != ST_INSEN && !(ack_rise && st_reg.fsm == ST_EDGE)
         && !(ack_level && wait_done)) |=> (bus_error && !busy))
        else $error("no bus error at time-out");

    chk_edge_end: assert property (
        (st_reg.fsm == ST_EDGE && ack_rise) |=> (xfer_end && !busy && !bus_error))
        else $error("edge did not end transfer");

    chk_edge_cs5: assert property (
        (st_reg.fsm == ST_IDLE && req.start && req.cs_sel != EDGE_CS) |=> st_reg.fsm != ST_EDGE)
        else $error("edge mode on wrong select");

    chk_sync_unused: assert property (
        (st_reg.fsm == ST_IDLE && req.start && sel_cfg.sync_mode) |=> !busy)
        else $error("acknowledge used in synchronous mode");

    chk_insens_min: assert property (
        s_level_start |=> (st_reg.fsm == ST_INSEN) [*2])
        else $error("insensitivity shorter than two");

    chk_insens_max: assert property (
        s_level_start |-> ##[1:6] (st_reg.fsm != ST_INSEN))
        else $error("insensitivity longer than five");

    chk_low_stall: assert property (
        ((st_reg.fsm == ST_WAIT || st_reg.fsm == ST_PASS) && !ack_level && !timed_out) |=> (stall && !xfer_end))
        else $error("low acknowledge did not pause");

    chk_cs4_level: assert property (
        (st_reg.fsm == ST_IDLE && req.start && req.cs_sel == SHARED_CS && !ack_edge_select) |=> !busy)
        else $error("level mode on shared select");

    chk_fresh_window: assert property (
        (st_reg.fsm == ST_IDLE) |=> (st_reg.tcnt == CNT_ZERO))
        else $error("time-out not restarted");

    // ------------------------------------------------------------
    // Further sequences and properties
    // ------------------------------------------------------------
    // Level cycle past its mask, in either waiting sub-state
    sequence s_level_open;
        st_reg.fsm == ST_WAIT || st_reg.fsm == ST_PASS;
    endsequence

    // Edge cycle still waiting: no rise and no time-out yet
    sequence s_edge_hold;
        st_reg.fsm == ST_EDGE && !ack_rise && !timed_out;
    endsequence

    // The two endings exclude each other
    chk_end_exclusive: assert property (
        !(xfer_end && bus_error))
        else $error("end and error together");

    // Error is a single pulse, so the master sees it once
    chk_error_pulse: assert property (
        bus_error |=> !bus_error)
        else $error("error pulse too long");

    // End is a single pulse
    chk_end_pulse: assert property (
        xfer_end |=> !xfer_end)
        else $error("end pulse too long");

    // Each edge cycle holds and stalls the bus in the cycle after its start
    chk_edge_hold: assert property (
        s_edge_start |=> (busy && stall))
        else $error("edge cycle not held");

    // Without a rise the edge cycle keeps waiting
    chk_edge_wait: assert property (
        s_edge_hold |=> (busy && stall && !xfer_end))
        else $error("edge cycle ended without rise");

    // No ending while the acknowledge is ignored
    chk_insens_mask: assert property (
        (st_reg.fsm == ST_INSEN) |=> (busy && !xfer_end && !bus_error))
        else $error("ending inside insensitivity");

    // High acknowledge with waits done ends the level cycle
    chk_level_end: assert property (
        ((st_reg.fsm == ST_WAIT || st_reg.fsm == ST_PASS) && ack_level && wait_done) |=> (xfer_end && !busy))
        else $error("level cycle did not end");

    // High acknowledge lets the transfer run on
    chk_level_run: assert property (
        (s_level_open ##0 ack_level) |=> !stall)
        else $error("stall with high acknowledge");

    // A pause only ever belongs to an open cycle
    chk_stall_busy: assert property (
        stall |-> busy)
        else $error("stall outside a cycle");

    // Timer advances by one every cycle a bus cycle is open
    chk_timer_step: assert property (
        (st_reg.fsm != ST_IDLE) |=> (st_reg.tcnt == $past(st_reg.tcnt) + CNT_ONE))
        else $error("time-out counter skipped");

    // A flagged setup stays flagged until reset
    chk_cfg_sticky: assert property (
        cfg_error |=> cfg_error)
        else $error("setup flag lost");

endmodule

// *** rtl/ebat_pkg.sv ***
package ebat_pkg;

    // ------------------------------------------------------------
    // Timing constants
    // ------------------------------------------------------------
    localparam int unsigned TIMEOUT_CYCLES   = 1024;    // Bus cycle time-out in system clocks
    localparam int unsigned INSENS_MIN_CYC   = 2;       // Shortest insensitivity window
    localparam int unsigned INSENS_MAX_CYC   = 5;       // Longest insensitivity window
    localparam int unsigned CNT_W            = 11;      // Time-out counter width
    localparam int unsigned INS_W            = 3;       // Insensitivity counter width

    // ------------------------------------------------------------
    // Chip-select numbering and configuration values
    // ------------------------------------------------------------
    localparam int unsigned NUM_CS           = 6;
    localparam logic [2:0]  EDGE_CS          = 3'h5;    // Only select allowed in edge mode
    localparam logic [2:0]  SHARED_CS        = 3'h4;    // Select whose pin carries the acknowledge
    localparam logic [5:0]  EDGE_WAIT_COUNT  = 6'h3f;   // Wait count that marks edge mode
    localparam logic [3:0]  EDGE_DELAY_MIN   = 4'h1;
    localparam logic [5:0]  LEVEL_WAIT_MIN   = 6'h1;    // Wait count must exceed this
    localparam logic [3:0]  LEVEL_NEGATE_MAX = 4'h3;    // Negate delay must be below this
    localparam logic [5:0]  WAIT_ZERO        = 6'h0;
    localparam logic [2:0]  INS_ZERO         = 3'h0;
    localparam logic [CNT_W-1:0] CNT_ZERO    = 11'h000;
    localparam logic [CNT_W-1:0] CNT_ONE     = 11'h001;

    // Per-select configuration as seen by this block
    typedef struct packed {
        logic       sync_mode;                  // Synchronous burst mode
        logic       external_wait_enable;
        logic [5:0] wait_state_count;
        logic [3:0] select_assert_delay;
        logic [3:0] select_negate_delay;
        logic [1:0] ack_insensitivity_time;     // 0..3 -> 2..5 cycles
    } ebat_cs_cfg_s;

    // Transfer request from the chip-select engine
    typedef struct packed {
        logic       start;                      // One-cycle pulse at cycle start
        logic [2:0] cs_sel;
    } ebat_req_s;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_INSEN = 3'b001,
        ST_WAIT  = 3'b011,
        ST_EDGE  = 3'b010,
        ST_PASS  = 3'b110
    } ebat_state_e;

endpackage

// *** rtl/ebat_sync.sv ***
module ebat_sync
    import ebat_pkg::*;
(
    input  wire logic core_clk,     // System clock
    input  wire logic sys_rst,      // Synchronous reset
    input  wire logic async_in,     // Raw pin level
    output logic      level_out,    // Debounced level
    output logic      rise_pulse    // One-cycle rising edge
);

    // ------------------------------------------------------------
    // Three-stage capture
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] stage;
        logic       level;
        logic       rise;
    } ebat_sync_s;

    ebat_sync_s st_reg;
    ebat_sync_s st_next;

    // Level changes only when stages two and three agree
    always_comb begin
        st_next       = st_reg;
        st_next.stage = {st_reg.stage[1:0], async_in};
        st_next.rise  = 1'b0;
        if (st_reg.stage[1] == st_reg.stage[2]) begin
            st_next.level = st_reg.stage[2];
            st_next.rise  = st_reg.stage[2] & ~st_reg.level;
        end
    end

    // Reset to high: the idle acknowledge is released
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_reg <= '{stage: 3'h7, level: 1'b1, rise: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_out  = st_reg.level;
    assign rise_pulse = st_reg.rise;

endmodule

// *** test/ebat_ack_dev.sv ***
// ------------------------------------------------------------
// Far-side device that answers each bus cycle on the ack pin
// ------------------------------------------------------------
module ebat_ack_dev (
    input  wire logic core_clk,   // System clock
    input  wire logic busy,       // Bus cycle in progress
    input  int        low_cycles, // Cycles ack stays low, 0 = never low
    output logic      ack         // Acknowledge pin
);
    timeunit 1ns;
    timeprecision 100ps;

    int   cnt    = 0;
    logic busy_d = 1'b0;
    logic ack_q  = 1'b1;

    assign ack = ack_q;

    // Low at cycle start, high after the delay; a long delay models a dead card
    always @(posedge core_clk) begin
        busy_d <= busy;
        if (busy && !busy_d) begin
            cnt   <= low_cycles;
            ack_q <= (low_cycles == 0);
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else if (cnt == 1) begin
            cnt   <= 0;
            ack_q <= 1'b1;
        end
    end
endmodule

// *** test/ebat_core_bench.sv ***
module ebat_core_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import ebat_pkg::*;

    localparam int unsigned TMO = 16; // Short time-out keeps the run brief
    logic                  core_clk = 1'b0, sys_rst = 1'b1, ack_edge_select = 1'b0, wait_done = 1'b0;
    logic                  transfer_ack_in, busy, stall, xfer_end, bus_error, cfg_error;
    ebat_cs_cfg_s [NUM_CS-1:0] cs_cfg = '0;
    ebat_req_s             req = '0;
    int                    low_cycles = 0, n_fail = 0, compares = 0, n;
    logic                  ended, err, saw_stall;

    always #2 core_clk = ~core_clk;

    ebat_core #(.TIMEOUT(TMO)) i_ebat_core (.core_clk(core_clk), .sys_rst(sys_rst),
        .transfer_ack_in(transfer_ack_in), .ack_edge_select(ack_edge_select), .cs_cfg(cs_cfg),
        .req(req), .wait_done(wait_done), .busy(busy), .stall(stall), .xfer_end(xfer_end),
        .bus_error(bus_error), .cfg_error(cfg_error));
    ebat_ack_dev i_ebat_ack_dev (.core_clk(core_clk), .busy(busy), .low_cycles(low_cycles),
        .ack(transfer_ack_in));

    // ------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------
    task automatic check_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_cnt(input int got, input int exp);
        compares++;
        if (got != exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Bus helpers
    // ------------------------------------------------------------
    // Software setup of one select, edge or level flavour
    task automatic set_cfg(input logic [2:0] sel, input logic em, input logic [1:0] ins);
        @(posedge core_clk);
        ack_edge_select <= em;
        cs_cfg[sel] <= '{sync_mode: 1'b0, external_wait_enable: !em,
                         wait_state_count: em ? EDGE_WAIT_COUNT : 6'h04, select_assert_delay: 4'h1,
                         select_negate_delay: 4'h1, ack_insensitivity_time: ins};
    endtask

    // One cycle; n counts edges from the taking edge to the end or error pulse
    task automatic xfer(input logic [2:0] sel);
        @(posedge core_clk) req <= '{start: 1'b1, cs_sel: sel};
        @(posedge core_clk) req.start <= 1'b0;
        n = 0;
        ended = 1'b0;
        err = 1'b0;
        saw_stall = 1'b0;
        while (!ended && !err) begin
            @(posedge core_clk);
            #1;
            n++;
            ended = (xfer_end === 1'b1);
            err = (bus_error === 1'b1);
            saw_stall = saw_stall | (stall === 1'b1);
            if (n > 200) begin
                n_fail++;
                $display("Error at %0t: got %h expected %h", $time, n, 200);
                report_and_stop;
            end
        end
    endtask

    // A request that must be turned away
    task automatic refuse(input logic [2:0] sel);
        @(posedge core_clk) req <= '{start: 1'b1, cs_sel: sel};
        @(posedge core_clk) req.start <= 1'b0;
        repeat (4) begin
            @(posedge core_clk);
            #1;
            check_bit(busy, 1'b0);
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Two back-to-back edge cycles on select five, each waits its own rise
    task automatic t_edge;
        set_cfg(3'h5, 1'b1, 2'h0);
        low_cycles = 6;
        repeat (2) begin
            xfer(3'h5);
            check_bit(err, 1'b0);
            check_bit(saw_stall, 1'b1);
            check_bit(n >= 9, 1'b1);
        end
    endtask

    // Every insensitivity code, then a long low ack that stalls
    task automatic t_level;
        @(posedge core_clk) wait_done <= 1'b1;
        low_cycles = 0;
        for (int i = 0; i < 4; i++) begin
            set_cfg(3'h0, 1'b0, i[1:0]);
            xfer(3'h0);
            check_cnt(n, 1 + INSENS_MIN_CYC + i);
        end
        // Short enough that the synced rise lands before the time-out
        low_cycles = 8;
        xfer(3'h0);
        check_bit(saw_stall, 1'b1);
        check_bit(ended && n >= 12, 1'b1);
    endtask

    // Dead card in both modes; each cycle gets the full window again
    task automatic t_timeout;
        low_cycles = 5000;
        repeat (2) begin
            xfer(3'h0);
            check_bit(err, 1'b1);
            check_cnt(n, TMO);
            check_bit(busy, 1'b0);
        end
        // Card stays dead: the pin never rises, so no edge can end the cycle
        set_cfg(3'h5, 1'b1, 2'h0);
        xfer(3'h5);
        check_bit(err, 1'b1);
        check_cnt(n, TMO);
    endtask

    // Modes asked of selects that cannot have them
    task automatic t_refuse;
        check_bit(cfg_error, 1'b0);
        set_cfg(3'h3, 1'b1, 2'h0);
        refuse(3'h3);
        check_bit(cfg_error, 1'b1);
        set_cfg(3'h4, 1'b0, 2'h0);
        refuse(3'h4);
        set_cfg(3'h0, 1'b0, 2'h0);
        @(posedge core_clk) cs_cfg[0].sync_mode <= 1'b1;
        refuse(3'h0);
    endtask

    // Reset five cycles, then the scenarios
    initial begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_edge;
        t_level;
        t_timeout;
        t_refuse;
        report_and_stop;
    end
endmodule
